// file: irq_status_pkg.sv
// Package with offsets, bit positions and reset values of the event status block
package irq_status_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] STATUS_OFFSET = 8'h58;
	localparam logic [7:0] BYTE_ORDER_OFFSET = 8'h64;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	// Hardware-set flags cleared by writing one, plus the read-only transceiver bit 18
	localparam logic [31:0] CLEARABLE_MASK = 32'h83bf_e7df;
	// ==========================================================
	// Flag bit positions
	localparam int SOFTWARE_REQUEST_BIT = 31;
	localparam int TRANSMITTER_HALTED_BIT = 25;
	localparam int RECEIVER_HALTED_BIT = 24;
	localparam int DROP_MIDPOINT_BIT = 23;
	localparam int BUFFER_COMPLETION_BIT = 21;
	localparam int RECEIVE_DMA_BIT = 20;
	localparam int TIMER_WRAP_BIT = 19;
	localparam int TRANSCEIVER_BIT = 18;
	localparam int POWER_EVENT_BIT = 17;
	localparam int TX_STATUS_OVERFLOW_BIT = 16;
	localparam int RECEIVE_WATCHDOG_BIT = 15;
	localparam int RECEIVE_ERROR_BIT = 14;
	localparam int TRANSMIT_ERROR_BIT = 13;
	localparam int TX_DATA_OVERRUN_BIT = 10;
	localparam int TX_SPACE_BIT = 9;
	localparam int TX_STATUS_FULL_BIT = 8;
	localparam int TX_STATUS_LEVEL_BIT = 7;
	localparam int FRAME_DROPPED_BIT = 6;
	localparam int RX_STATUS_FULL_BIT = 4;
	localparam int RX_STATUS_LEVEL_BIT = 3;
	localparam int PIN_EVENT_LSB = 0;
	// ==========================================================
	// Source thresholds
	localparam logic [31:0] DROP_MIDPOINT = 32'h8000_0000;
	localparam logic [15:0] TIMER_WRAP_VALUE = 16'hffff;
	localparam int WATCHDOG_BYTES = 2048;
	localparam int PIN_SYNC_STAGES = 3;
endpackage

// file: edge_sync.sv
// Three-stage pin synchroniser with rising edge pulse
module edge_sync (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic pin_i,
	output logic rise_o
);
	logic [2:0] stage_reg;
	logic rise_seen_reg;

	// Stage 0 feeds only stage 1; a change counts when stages 1 and 2 agree
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stage_reg <= 3'h0;
		end else begin
			stage_reg <= {stage_reg[1:0], pin_i};
		end
	end

	// Output from a flop so the pulse is clean
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rise_o <= 1'b0;
		end else begin
			rise_o <= stage_reg[1] & stage_reg[2] & ~rise_seen_reg;
		end
	end

	// Remember the agreed level so one change pulses once
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rise_seen_reg <= 1'b0;
		end else if (stage_reg[1] == stage_reg[2]) begin
			rise_seen_reg <= stage_reg[2];
		end
	end
endmodule // edge_sync

// file: irq_event_status.sv
// Interrupt event status register with write-one-to-clear flags
// Summary of operation
// - Status register at 58h, write one clears
// - Bit 31 set by software request control
// - Bit 25 set when stopped transmitter halts
// - Bit 24 set when receiver halts
// - Bit 23 set when drop counter reaches midpoint
// - Bit 21 set on notify buffer completion
// - Bit 20 set when receive DMA count done
// - Bit 19 set when timer wraps to FFFFh
// - Bit 18 read-only, mirrors transceiver event
// - Bit 17 power event, independent of pin
// - Only byte-order register write wakes device
// - Hold-off interval never applies to power event
// - Bit 16 set on transmit status overflow
// - Bit 15 set on over-long received packet
// - Bit 14 set on receive error
// - Bit 13 set on transmit error
// - Bit 10 set on write to full FIFO
// - Bit 9 set when free space exceeds threshold
// - Bits 8 and 4 set on status FIFO full
// - Bits 7 and 3 set on status level reached
// - Bit 6 set on each dropped frame
// - Bits 2-0 latch GPIO pin events
// - Flags record events regardless of enable mask
module irq_event_status
	import irq_status_pkg::*;
#(
	parameter int PIN_COUNT = 3,
	parameter int ADDR_WIDTH = 8
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [ADDR_WIDTH-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic software_request_control_i,
	input wire logic stop_transmit_control_i,
	input wire logic transmitter_idle_i,
	input wire logic receiver_halted_i,
	input wire logic drop_count_inc_i,
	input wire logic [31:0] drop_count_i,
	input wire logic buffer_done_i,
	input wire logic completion_notify_marker_i,
	input wire logic receive_dma_done_i,
	input wire logic timer_dec_i,
	input wire logic [15:0] timer_count_i,
	input wire logic transceiver_event_i,
	input wire logic power_event_i,
	input wire logic tx_status_overflow_i,
	input wire logic receive_frame_end_i,
	input wire logic [15:0] receive_frame_len_i,
	input wire logic receive_error_i,
	input wire logic transmit_error_i,
	input wire logic tx_data_write_i,
	input wire logic tx_data_full_i,
	input wire logic [7:0] tx_free_blocks_i,
	input wire logic [7:0] tx_space_level_i,
	input wire logic tx_status_full_i,
	input wire logic tx_status_level_i,
	input wire logic frame_dropped_i,
	input wire logic rx_status_full_i,
	input wire logic rx_status_level_i,
	input wire logic [PIN_COUNT-1:0] pin_event_pins_i,
	output logic [31:0] interrupt_event_status_o,
	output logic wake_request_o,
	output logic power_event_flag_o
);
	// ==========================================================
	// Pin synchronisers
	logic [PIN_COUNT-1:0] pin_rise;
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : gen_pin
			edge_sync u_sync (
				.core_clk_i(core_clk_i),
				.resetn_i(resetn_i),
				.pin_i(pin_event_pins_i[g]),
				.rise_o(pin_rise[g])
			);
		end
	endgenerate

	// ==========================================================
	// Source event detection
	logic [31:0] set_vec;
	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [31:0] clear_vec;
	logic status_wr;
	logic soft_ctrl_reg;
	logic tx_halt_reg;
	logic tx_halt_now;

	assign tx_halt_now = stop_transmit_control_i & transmitter_idle_i;

	// Edge memory so the software request and transmitter halt sources set a flag once per assertion
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			soft_ctrl_reg <= 1'b0;
			tx_halt_reg <= 1'b0;
		end else begin
			soft_ctrl_reg <= software_request_control_i;
			tx_halt_reg <= tx_halt_now;
		end
	end

	// Event vector; each source is a strobe or edge from same clock logic
	always_comb begin
		set_vec = 32'h0000_0000;
		set_vec[SOFTWARE_REQUEST_BIT] = software_request_control_i
			& ~soft_ctrl_reg;
		set_vec[TRANSMITTER_HALTED_BIT] = tx_halt_now & ~tx_halt_reg;
		set_vec[RECEIVER_HALTED_BIT] = receiver_halted_i;
		set_vec[DROP_MIDPOINT_BIT] = drop_count_inc_i
			& (drop_count_i == DROP_MIDPOINT - 32'h1);
		set_vec[BUFFER_COMPLETION_BIT] = buffer_done_i
			& completion_notify_marker_i;
		set_vec[RECEIVE_DMA_BIT] = receive_dma_done_i;
		set_vec[TIMER_WRAP_BIT] = timer_dec_i
			& (timer_count_i == 16'h0000);
		set_vec[POWER_EVENT_BIT] = power_event_i;
		set_vec[TX_STATUS_OVERFLOW_BIT] = tx_status_overflow_i;
		set_vec[RECEIVE_WATCHDOG_BIT] = receive_frame_end_i
			& (receive_frame_len_i > 16'(WATCHDOG_BYTES));
		set_vec[RECEIVE_ERROR_BIT] = receive_error_i;
		set_vec[TRANSMIT_ERROR_BIT] = transmit_error_i;
		set_vec[TX_DATA_OVERRUN_BIT] = tx_data_write_i
			& tx_data_full_i;
		set_vec[TX_SPACE_BIT] = tx_free_blocks_i > tx_space_level_i;
		set_vec[TX_STATUS_FULL_BIT] = tx_status_full_i;
		set_vec[RX_STATUS_FULL_BIT] = rx_status_full_i;
		set_vec[TX_STATUS_LEVEL_BIT] = tx_status_level_i;
		set_vec[RX_STATUS_LEVEL_BIT] = rx_status_level_i;
		set_vec[FRAME_DROPPED_BIT] = frame_dropped_i;
		set_vec[PIN_EVENT_LSB +: PIN_COUNT] = pin_rise;
	end

	// ==========================================================
	// Status register
	assign status_wr = wr_i & (addr_i == STATUS_OFFSET);
	// Only ones written to clearable bits act; zeros leave flags alone
	assign clear_vec = status_wr ? (wdata_i & CLEARABLE_MASK) : 32'h0;

	// Set wins over clear so an event in the clear cycle is kept
	always_comb begin
		status_next = ((status_reg & ~clear_vec) | set_vec)
			& CLEARABLE_MASK;
		// Transceiver bit is a live mirror and ignores writes
		status_next[TRANSCEIVER_BIT] = transceiver_event_i;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_reg <= STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	assign interrupt_event_status_o = status_reg;
	// Raw power flag bypasses any hold-off interval elsewhere
	assign power_event_flag_o = status_reg[POWER_EVENT_BIT];

	// ==========================================================
	// Wake request: only a write to the byte-order register wakes
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wake_request_o <= 1'b0;
		end else begin
			wake_request_o <= wr_i & (addr_i == BYTE_ORDER_OFFSET);
		end
	end

	// ==========================================================
	// Read port; unmapped addresses answer zero
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i && addr_i == STATUS_OFFSET) begin
			rdata_o <= status_reg;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Checks
	AST_W1C_CLEARS: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		status_wr && wdata_i[RECEIVE_DMA_BIT] && !receive_dma_done_i
		|=> !status_reg[RECEIVE_DMA_BIT])
		else $error("write one did not clear flag");
	AST_SW_SET: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		$rose(software_request_control_i) |=> status_reg[SOFTWARE_REQUEST_BIT])
		else $error("software request flag not set");
	AST_TX_HALT: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		tx_halt_now && !tx_halt_reg |=> status_reg[TRANSMITTER_HALTED_BIT])
		else $error("transmitter halt flag not set");
	AST_MIDPOINT: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		drop_count_inc_i && drop_count_i == 32'h7fff_ffff
		|=> status_reg[DROP_MIDPOINT_BIT])
		else $error("drop midpoint flag not set");
	AST_TIMER: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		!status_reg[TIMER_WRAP_BIT] && !(timer_dec_i && timer_count_i == 16'h0)
		|=> !status_reg[TIMER_WRAP_BIT])
		else $error("timer flag set without wrap");
	AST_PHY_RO: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		##1 status_reg[TRANSCEIVER_BIT] == $past(transceiver_event_i))
		else $error("transceiver bit not mirroring");
	AST_WATCHDOG: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		receive_frame_end_i && receive_frame_len_i == 16'd2048
		&& !status_reg[RECEIVE_WATCHDOG_BIT]
		|=> !status_reg[RECEIVE_WATCHDOG_BIT])
		else $error("watchdog set at exactly 2048 bytes");
	AST_SET_WINS: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		frame_dropped_i && status_wr |=> status_reg[FRAME_DROPPED_BIT])
		else $error("event lost during clear");
	AST_RESERVED: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		(status_reg & ~(CLEARABLE_MASK | 32'h0004_0000)) == 32'h0)
		else $error("reserved bit set");
	AST_WAKE: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		wake_request_o |-> $past(wr_i) && $past(addr_i) == BYTE_ORDER_OFFSET)
		else $error("wake without byte-order write");
	AST_ZERO_WRITE: assert property (@(posedge core_clk_i)
		disable iff (!resetn_i)
		status_wr && !wdata_i[RECEIVE_ERROR_BIT] && status_reg[RECEIVE_ERROR_BIT]
		|=> status_reg[RECEIVE_ERROR_BIT])
		else $error("zero write cleared flag");

	COV_CLEAR: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		status_wr && wdata_i != 32'h0);
	COV_READ: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		rd_i && addr_i == STATUS_OFFSET && status_reg != 32'h0);
	COV_PIN: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		|pin_rise);
	COV_WAKE: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
		wake_request_o && power_event_flag_o);
endmodule // irq_event_status

// file: tb_top.sv
// Self-checking testbench for the interrupt event status register
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_status_pkg::*;
	// ==========================================================
	// Stimulus signals, named after the ports for implicit hookup
	logic core_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0;
	logic [7:0] addr_i = 0, tx_free_blocks_i = 0, tx_space_level_i = 0;
	logic [31:0] wdata_i = 0, drop_count_i = 0;
	logic [15:0] timer_count_i = 0, receive_frame_len_i = 0;
	logic [2:0] pin_event_pins_i = 0;
	logic software_request_control_i = 0, stop_transmit_control_i = 0;
	logic transmitter_idle_i = 0, receiver_halted_i = 0;
	logic drop_count_inc_i = 0, buffer_done_i = 0;
	logic completion_notify_marker_i = 0, receive_dma_done_i = 0;
	logic timer_dec_i = 0, transceiver_event_i = 0, power_event_i = 0;
	logic tx_status_overflow_i = 0, receive_frame_end_i = 0;
	logic receive_error_i = 0, transmit_error_i = 0, tx_data_write_i = 0;
	logic tx_data_full_i = 0, tx_status_full_i = 0, tx_status_level_i = 0;
	logic frame_dropped_i = 0, rx_status_full_i = 0, rx_status_level_i = 0;
	logic [31:0] rdata_o, interrupt_event_status_o, exp, w;
	logic wake_request_o, power_event_flag_o;
	logic [21:0] m;
	int err_total = 0, num_checks = 0;
	// Flag bit for each source index; pins occupy the last three
	int bits[22] = '{31, 25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 10, 9,
		8, 7, 6, 4, 3, 0, 1, 2};
	// Sources whose flag depends on a qualifier that can be made false
	localparam logic [21:0] QUAL = 22'h0325a;

	irq_event_status DUT (.*);

	always #20 core_clk_i = ~core_clk_i;

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Bus write: one strobe cycle, result settled just after the next edge
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// Read data only stand in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] want);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, want);
	endtask

	function automatic logic [31:0] flag(input int k, input bit q);
		return q ? (32'h1 << bits[k]) : 32'h0;
	endfunction

	// Raise or drop one source; q false spoils its qualifier
	task automatic drive(input int k, input bit v, input bit q);
		int r;
		r = $urandom % 255;
		case (k)
			0: software_request_control_i <= v;
			1: begin
				stop_transmit_control_i <= v & q;
				transmitter_idle_i <= v;
			end
			2: receiver_halted_i <= v;
			3: begin
				drop_count_inc_i <= v;
				drop_count_i <= q ? 32'h7fff_ffff : $urandom % 32'h7fff_ffff;
			end
			4: begin
				buffer_done_i <= v;
				completion_notify_marker_i <= v & q;
			end
			5: receive_dma_done_i <= v;
			6: begin
				timer_dec_i <= v;
				timer_count_i <= q ? 16'h0 : 16'(1 + $urandom % 16'hfffe);
			end
			7: power_event_i <= v;
			8: tx_status_overflow_i <= v;
			9: begin
				// Exactly 2048 bytes must not count as over-long
				receive_frame_end_i <= v;
				receive_frame_len_i <= q ? 16'd2049 : 16'd2048;
			end
			10: receive_error_i <= v;
			11: transmit_error_i <= v;
			12: begin
				tx_data_write_i <= v;
				tx_data_full_i <= v & q;
			end
			13: begin
				tx_space_level_i <= 8'(r);
				tx_free_blocks_i <= v ? 8'(q ? r + 1 : r) : 8'h0;
			end
			14: tx_status_full_i <= v;
			15: tx_status_level_i <= v;
			16: frame_dropped_i <= v;
			17: rx_status_full_i <= v;
			18: rx_status_level_i <= v;
			default: pin_event_pins_i[k-19] <= v;
		endcase
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(98));
		repeat (2) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		#1 chk(interrupt_event_status_o, 32'h0);
		rd_reg(STATUS_OFFSET, 32'h0);
		$display("Test reset finished");
		// Every source alone with its qualifier; sources in QUAL also without it
		for (int k = 0; k < 22; k++) begin
			for (int q = 0; q < 2; q++) begin
				if (q == 1 || QUAL[k]) begin
					@(posedge core_clk_i);
					drive(k, 1'b1, q[0]);
					// Two cycles so a pin level reaches both agreeing sync stages
					repeat (2) @(posedge core_clk_i);
					drive(k, 1'b0, q[0]);
					repeat (5) @(posedge core_clk_i);
					#1 exp = flag(k, q[0]);
					chk(interrupt_event_status_o, exp);
					if (k == 7)
						chk(32'(power_event_flag_o), 32'(q));
					wr_reg(STATUS_OFFSET, ~exp);
					chk(interrupt_event_status_o, exp);
					rd_reg(STATUS_OFFSET, exp);
					wr_reg(STATUS_OFFSET, exp);
					chk(interrupt_event_status_o, 32'h0);
				end
			end
		end
		$display("Test single sources finished");
		// Transceiver flag mirrors its input and ignores clears
		transceiver_event_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		wr_reg(STATUS_OFFSET, 32'hffff_ffff);
		chk(interrupt_event_status_o, 32'h0004_0000);
		transceiver_event_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1 chk(interrupt_event_status_o, 32'h0);
		$display("Test transceiver flag finished");
		// Only a byte-order register write raises the wake pulse
		wr_reg(STATUS_OFFSET, 32'h0);
		chk(32'(wake_request_o), 32'h0);
		wr_reg(BYTE_ORDER_OFFSET, $urandom);
		chk(32'(wake_request_o), 32'h1);
		@(posedge core_clk_i);
		#1 chk(32'(wake_request_o), 32'h0);
		$display("Test wake finished");
		// Random groups of events, random partial clears
		repeat (12) begin
			m = 22'($urandom);
			exp = 32'h0;
			@(posedge core_clk_i);
			for (int k = 0; k < 22; k++)
				if (m[k])
					drive(k, 1'b1, 1'b1);
			repeat (2) @(posedge core_clk_i);
			for (int k = 0; k < 22; k++)
				if (m[k]) begin
					drive(k, 1'b0, 1'b1);
					exp |= flag(k, 1'b1);
				end
			repeat (5) @(posedge core_clk_i);
			#1 chk(interrupt_event_status_o, exp);
			rd_reg(8'h5c, 32'h0);
			w = $urandom;
			wr_reg(STATUS_OFFSET, w);
			exp &= ~w;
			chk(interrupt_event_status_o, exp);
			wr_reg(STATUS_OFFSET, 32'hffff_ffff);
			chk(interrupt_event_status_o, 32'h0);
		end
		$display("Test random clears finished");
		tally_and_finish();
	end

	// Cut a hang short well under the run budget
	initial begin
		#2000000;
		err_total++;
		tally_and_finish();
	end
endmodule // tb_top
